// file: infrared_port_frontend.sv
// Infrared modulation, half-duplex turnaround and transmit pin control
//
// What this block does
// - Pulse-coded mode runs at bit rates up to 115.2 kbps.
// - Pulse-coded zero is one short pulse at bit start; one sends nothing.
// - Carrier-keyed mode runs at bit rates up to 19.2K baud.
// - Carrier-keyed zero is 500kHz carrier for the whole bit; one sends nothing.
// - In half duplex a turnaround timer starts after last sent bit, blocking receive.
// - Loading another byte restarts the timer after that byte is sent.
// - Byte loaded while receiving waits for timer expiry after receive ends.
// - New start bit during timer restarts timer after that character.
// - Timeout programmable 0 to 10 ms in 100 us steps.
// - After standby reset both transmit pins drive low until enabled.
// - Infrared output pin defaults to infrared transmit function.
// - Infrared output pin low until activate set, then follows infrared transmit when routed to alternate pins.
// - In general-purpose function it follows its data bit when an output.
// - Serial transmit pin defaults to general-purpose output function.
// - Serial transmit pin low until serial function and activate, then transmits.
// - Tristate-select bit floats serial transmit pin regardless of anything else.
// - Tristate survives main supply loss; only standby reset clears it.
// - In general-purpose mode pin high only when exactly one of data and polarity bits is set.
// - Tristate-select bit never affects the infrared output pin.
// - Infrared traffic routes over standard serial pins or alternate infrared pins.
`timescale 1ns/100ps
`default_nettype none
module infrared_port_frontend
    import infrared_port_frontend_pkg::*;
#(
    parameter int STEP_CYC = STEP_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_main_por,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic i_uart_txd,
    input wire logic i_uart_bit_start,
    input wire logic i_uart_tx_busy,
    input wire logic i_uart_rx_busy,
    input wire logic i_baud_tick16,
    output logic o_uart_rxd,
    output logic o_uart_tx_hold,
    input wire logic i_infrared_in_pin,
    input wire logic i_second_serial_rx_pin,
    output logic o_infrared_out_pin,
    output logic o_second_serial_tx_pin,
    output logic o_second_serial_tx_pin_oe
);
    ////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [1:0] por_sync;
        logic [1:0] irin_sync;
        logic [1:0] rxin_sync;
        logic rx_prev;
        logic [7:0] mode;
        logic [6:0] control;
        logic [6:0] timeout;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
        logic [3:0] pulse_cnt;
        logic [8:0] carrier_cnt;
        logic carrier;
        logic [9:0] rx_hold;
        logic [3:0] rx_ticks;
        logic tx_busy_d;
        logic rx_busy_d;
        logic timer_run;
        logic turn_tx;
        logic [20:0] timer_cnt;
        logic [6:0] timer_steps;
        logic irout;
        logic txpin;
        logic txoe;
        logic rxd;
        logic hold;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;

    ////////////////////////////////////////////////////////////////////
    // Next state
    logic main_rst;
    ir_mode_t ir_mode;
    logic ir_on;
    logic ir_tx;
    logic raw_rx;
    logic ir_rx_seen;
    logic blocked;
    logic timer_done;
    logic [7:0] rd_word;
    logic addr_ok;

    always_comb begin
        nxt_ff = cur_ff;
        main_rst = cur_ff.por_sync[1];
        ir_mode = ir_mode_t'(cur_ff.mode[MODE_SEL_LO +: 2]);
        ir_on = (ir_mode == MODE_PULSE) || (ir_mode == MODE_ASK);
        nxt_ff.por_sync = {cur_ff.por_sync[0], i_main_por};
        nxt_ff.irin_sync = {cur_ff.irin_sync[0], i_infrared_in_pin};
        nxt_ff.rxin_sync = {cur_ff.rxin_sync[0], i_second_serial_rx_pin};

        // Register read mux
        addr_ok = 1'b1;
        rd_word = 8'h00;
        case (paddr)
            ADDR_CONTROL: rd_word = {1'b0, cur_ff.control};
            ADDR_STATUS: rd_word = {4'h0, cur_ff.hold, cur_ff.timer_run,
                                    cur_ff.rx_busy_d, cur_ff.tx_busy_d};
            ADDR_TIMEOUT: rd_word = {1'b0, cur_ff.timeout};
            ADDR_MODE: rd_word = cur_ff.mode;
            default: addr_ok = 1'b0;
        endcase

        // APB slave, one wait-free access phase
        nxt_ff.ready = 1'b0;
        nxt_ff.slverr = 1'b0;
        if (psel && !penable) begin
            nxt_ff.ready = 1'b1;
            nxt_ff.slverr = !addr_ok;
            nxt_ff.rdata = (!pwrite && addr_ok) ? {24'h00_0000, rd_word} : 32'h0000_0000;
        end
        if (psel && penable && cur_ff.ready && pwrite && addr_ok) begin
            case (paddr)
                ADDR_CONTROL: nxt_ff.control = pwdata[6:0];
                ADDR_TIMEOUT: begin
                    nxt_ff.timeout = (pwdata[6:0] > TIMEOUT_MAX) ? TIMEOUT_MAX
                                                                : pwdata[6:0];
                end
                ADDR_MODE: nxt_ff.mode = pwdata[7:0];
                default: nxt_ff.mode = cur_ff.mode;
            endcase
        end
        if (main_rst) begin
            nxt_ff.control = CONTROL_RESET;
            nxt_ff.mode[TRISTATE_BIT - 1:0] = MODE_RESET[TRISTATE_BIT - 1:0];
        end

        // Pulse-coded transmit: short pulse on zero bits
        if (i_uart_bit_start && !i_uart_txd) begin
            nxt_ff.pulse_cnt = PULSE_TICKS;
        end else if (i_baud_tick16 && cur_ff.pulse_cnt != 4'h0) begin
            nxt_ff.pulse_cnt = cur_ff.pulse_cnt - 4'h1;
        end

        // Carrier-keyed transmit: 500kHz square wave
        if (cur_ff.carrier_cnt == 9'(CARRIER_HALF_CYCLES - 1)) begin
            nxt_ff.carrier_cnt = 9'h000;
            nxt_ff.carrier = !cur_ff.carrier;
        end else begin
            nxt_ff.carrier_cnt = cur_ff.carrier_cnt + 9'h001;
        end

        case (ir_mode)
            MODE_PULSE: ir_tx = cur_ff.pulse_cnt != 4'h0;
            MODE_ASK: ir_tx = !i_uart_txd && cur_ff.carrier;
            default: ir_tx = !i_uart_txd;
        endcase

        // Receive decode, pin chosen by routing
        raw_rx = cur_ff.mode[ROUTE_ALT_BIT] ? cur_ff.irin_sync[1]
                                           : cur_ff.rxin_sync[1];
        nxt_ff.rx_prev = raw_rx;
        ir_rx_seen = raw_rx && !cur_ff.rx_prev;
        if (ir_mode == MODE_PULSE) begin
            if (ir_rx_seen) begin
                nxt_ff.rx_ticks = BIT_TICKS;
            end else if (i_baud_tick16 && cur_ff.rx_ticks != 4'h0) begin
                nxt_ff.rx_ticks = cur_ff.rx_ticks - 4'h1;
            end
        end else begin
            nxt_ff.rx_ticks = 4'h0;
        end
        if (ir_mode == MODE_ASK && ir_rx_seen) begin
            nxt_ff.rx_hold = ASK_HOLD_CYCLES;
        end else if (cur_ff.rx_hold != 10'h000) begin
            nxt_ff.rx_hold = cur_ff.rx_hold - 10'h001;
        end

        // Half-duplex turnaround timer
        nxt_ff.tx_busy_d = i_uart_tx_busy;
        nxt_ff.rx_busy_d = i_uart_rx_busy;
        timer_done = cur_ff.timer_steps >= cur_ff.timeout;
        if (i_uart_tx_busy || i_uart_rx_busy) begin
            nxt_ff.timer_run = 1'b0;
            nxt_ff.timer_cnt = 21'h00_0000;
            nxt_ff.timer_steps = 7'h00;
        end else if ((cur_ff.tx_busy_d || cur_ff.rx_busy_d)
                     && cur_ff.mode[HALF_DUPLEX_BIT]) begin
            nxt_ff.timer_run = 1'b1;
            nxt_ff.turn_tx = cur_ff.tx_busy_d;
            nxt_ff.timer_cnt = 21'h00_0000;
            nxt_ff.timer_steps = 7'h00;
        end else if (cur_ff.timer_run) begin
            if (timer_done) begin
                nxt_ff.timer_run = 1'b0;
            end else if (cur_ff.timer_cnt == 21'(STEP_CYC - 1)) begin
                nxt_ff.timer_cnt = 21'h00_0000;
                nxt_ff.timer_steps = cur_ff.timer_steps + 7'h01;
            end else begin
                nxt_ff.timer_cnt = cur_ff.timer_cnt + 21'h00_0001;
            end
        end
        if (!cur_ff.mode[HALF_DUPLEX_BIT]) begin
            nxt_ff.timer_run = 1'b0;
        end
        blocked = cur_ff.mode[HALF_DUPLEX_BIT] && cur_ff.timer_run
                  && cur_ff.turn_tx && !i_uart_rx_busy;
        nxt_ff.hold = cur_ff.mode[HALF_DUPLEX_BIT]
                      && (i_uart_rx_busy || (nxt_ff.timer_run && !nxt_ff.turn_tx
                      && !i_uart_tx_busy));

        // Receive line toward the UART
        if (blocked) begin
            nxt_ff.rxd = 1'b1;
        end else if (ir_mode == MODE_PULSE) begin
            nxt_ff.rxd = !(ir_rx_seen || cur_ff.rx_ticks != 4'h0);
        end else if (ir_mode == MODE_ASK) begin
            nxt_ff.rxd = !(ir_rx_seen || cur_ff.rx_hold != 10'h000);
        end else begin
            nxt_ff.rxd = raw_rx;
        end

        // Infrared output pin: infrared function by default
        if (cur_ff.control[IR_PIN_GPIO_BIT]) begin
            nxt_ff.irout = cur_ff.control[IR_GPIO_OUT_BIT]
                           && cur_ff.control[IR_GPIO_DATA_BIT];
        end else begin
            nxt_ff.irout = cur_ff.control[ACTIVATE_BIT] && cur_ff.mode[ROUTE_ALT_BIT]
                           && ir_on && ir_tx;
        end

        // Serial transmit pin: general-purpose by default
        if (cur_ff.control[TX_PIN_SERIAL_BIT]) begin
            if (!cur_ff.control[ACTIVATE_BIT]) begin
                nxt_ff.txpin = 1'b0;
            end else if (ir_on && !cur_ff.mode[ROUTE_ALT_BIT]) begin
                nxt_ff.txpin = ir_tx;
            end else begin
                nxt_ff.txpin = i_uart_txd;
            end
        end else begin
            nxt_ff.txpin = cur_ff.control[TX_GPIO_DATA_BIT]
                           ^ cur_ff.control[TX_GPIO_POL_BIT];
        end
        nxt_ff.txoe = !nxt_ff.mode[TRISTATE_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cur_ff <= '0;
            cur_ff.txoe <= 1'b1;
            cur_ff.rxd <= 1'b1;
            cur_ff.rx_prev <= 1'b0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign prdata = cur_ff.rdata;
    assign pready = cur_ff.ready;
    assign pslverr = cur_ff.slverr;
    assign o_uart_rxd = cur_ff.rxd;
    assign o_uart_tx_hold = cur_ff.hold;
    assign o_infrared_out_pin = cur_ff.irout;
    assign o_second_serial_tx_pin = cur_ff.txpin;
    assign o_second_serial_tx_pin_oe = cur_ff.txoe;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking dflt_cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    AST_TRISTATE_FLOATS: assert property (
        cur_ff.mode[TRISTATE_BIT] |-> !o_second_serial_tx_pin_oe)
        else $error("Tristate bit set but pin driven");
    AST_TRISTATE_KEEPS_MAIN_POR: assert property (
        cur_ff.mode[TRISTATE_BIT] && cur_ff.por_sync[1] |=> cur_ff.mode[TRISTATE_BIT])
        else $error("Main reset cleared tristate bit");
    AST_IR_LOW_INACTIVE: assert property (
        !cur_ff.control[ACTIVATE_BIT] && !cur_ff.control[IR_PIN_GPIO_BIT]
        |=> !o_infrared_out_pin)
        else $error("Infrared pin high while inactive");
    AST_IR_GPIO_FOLLOWS: assert property (
        cur_ff.control[IR_PIN_GPIO_BIT] |=> o_infrared_out_pin ==
        ($past(cur_ff.control[IR_GPIO_OUT_BIT]) && $past(cur_ff.control[IR_GPIO_DATA_BIT])))
        else $error("Infrared pin not following gpio data");
    AST_TX_GPIO_LEVEL: assert property (
        !cur_ff.control[TX_PIN_SERIAL_BIT] |=> o_second_serial_tx_pin ==
        ($past(cur_ff.control[TX_GPIO_DATA_BIT]) ^ $past(cur_ff.control[TX_GPIO_POL_BIT])))
        else $error("Transmit pin gpio level wrong");
    AST_TX_LOW_UNTIL_ACTIVE: assert property (
        cur_ff.control[TX_PIN_SERIAL_BIT] && !cur_ff.control[ACTIVATE_BIT]
        |=> !o_second_serial_tx_pin)
        else $error("Transmit pin high before activate");
    AST_PULSE_WIDTH: assert property (
        ir_mode == MODE_PULSE && i_uart_bit_start && !i_uart_txd
        |=> cur_ff.pulse_cnt == PULSE_TICKS)
        else $error("Pulse not started on zero bit");
    AST_ASK_CARRIER_HALF: assert property (
        $rose(cur_ff.carrier) |=> !$changed(cur_ff.carrier) [*8])
        else $error("Carrier toggles too fast");
    AST_RX_BLOCKED: assert property (
        blocked |=> o_uart_rxd)
        else $error("Receiver not blocked in turnaround");
    AST_TIMER_STOPS_ON_TX: assert property (
        i_uart_tx_busy |=> !cur_ff.timer_run)
        else $error("Turnaround timer runs during transmit");
    AST_HOLD_DURING_RX: assert property (
        cur_ff.mode[HALF_DUPLEX_BIT] && i_uart_rx_busy |=> o_uart_tx_hold)
        else $error("Transmit not held during receive");
    AST_TIMEOUT_LIMIT: assert property (
        cur_ff.timeout <= TIMEOUT_MAX)
        else $error("Timeout above limit");
    AST_TX_TURN_NO_HOLD: assert property (
        cur_ff.timer_run && cur_ff.turn_tx && !i_uart_rx_busy
        |=> !o_uart_tx_hold)
        else $error("Transmit held during transmit turnaround");
    AST_TX_TURN_START: assert property (
        cur_ff.mode[HALF_DUPLEX_BIT] && cur_ff.tx_busy_d && !i_uart_tx_busy
        && !i_uart_rx_busy |=> cur_ff.timer_run && cur_ff.turn_tx)
        else $error("Turnaround not started after transmit");
    AST_RX_TURN_RESTART: assert property (
        cur_ff.mode[HALF_DUPLEX_BIT] && cur_ff.rx_busy_d && !i_uart_rx_busy
        && !i_uart_tx_busy |=> cur_ff.timer_run && cur_ff.timer_steps == 7'h00)
        else $error("Turnaround not restarted after receive");
    AST_TIMER_OFF_FULL: assert property (
        !cur_ff.mode[HALF_DUPLEX_BIT] |=> !cur_ff.timer_run)
        else $error("Turnaround timer runs in full duplex");
    AST_HOLD_OFF_FULL: assert property (
        !cur_ff.mode[HALF_DUPLEX_BIT] |=> !o_uart_tx_hold)
        else $error("Transmit held in full duplex");
    AST_PULSE_RX_ZERO: assert property (
        ir_mode == MODE_PULSE && ir_rx_seen && !blocked |=> !o_uart_rxd)
        else $error("Received pulse not decoded as zero");
    AST_ASK_RX_ZERO: assert property (
        ir_mode == MODE_ASK && ir_rx_seen && !blocked |=> !o_uart_rxd)
        else $error("Received carrier not decoded as zero");
    AST_PULSE_ONE_DARK: assert property (
        ir_mode == MODE_PULSE && cur_ff.pulse_cnt == 4'h0
        && !cur_ff.control[IR_PIN_GPIO_BIT] |=> !o_infrared_out_pin)
        else $error("Infrared pin lit without pulse");
    AST_ASK_ONE_DARK: assert property (
        ir_mode == MODE_ASK && i_uart_txd && !cur_ff.control[IR_PIN_GPIO_BIT]
        |=> !o_infrared_out_pin)
        else $error("Carrier sent for a one bit");
    AST_IR_NOT_ROUTED: assert property (
        !cur_ff.control[IR_PIN_GPIO_BIT] && !cur_ff.mode[ROUTE_ALT_BIT]
        |=> !o_infrared_out_pin)
        else $error("Infrared pin active while not routed");
    AST_TX_CARRIES_IR: assert property (
        cur_ff.control[TX_PIN_SERIAL_BIT] && cur_ff.control[ACTIVATE_BIT] && ir_on
        && !cur_ff.mode[ROUTE_ALT_BIT] |=> o_second_serial_tx_pin == $past(ir_tx))
        else $error("Transmit pin not carrying infrared code");

    COV_TRISTATE: cover property (cur_ff.mode[TRISTATE_BIT] && cur_ff.por_sync[1]);
    COV_TIMER_EXPIRE: cover property (cur_ff.timer_run ##1 !cur_ff.timer_run);
    COV_ASK_TX: cover property (ir_mode == MODE_ASK && o_second_serial_tx_pin);
    COV_RX_BLOCKED: cover property (blocked && ir_rx_seen);
    COV_PULSE_TX: cover property (ir_mode == MODE_PULSE && o_infrared_out_pin);
endmodule : infrared_port_frontend
`default_nettype wire

// file: infrared_port_frontend_pkg.sv
// Constants for the infrared port front end
package infrared_port_frontend_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h08;
    localparam logic [7:0] ADDR_MODE = 8'hf0;
    // Mode register fields
    localparam int MODE_SEL_LO = 0;
    localparam int HALF_DUPLEX_BIT = 2;
    localparam int ROUTE_ALT_BIT = 3;
    localparam int TRISTATE_BIT = 5;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // Control register fields
    localparam int ACTIVATE_BIT = 0;
    localparam int IR_PIN_GPIO_BIT = 1;
    localparam int TX_PIN_SERIAL_BIT = 2;
    localparam int IR_GPIO_OUT_BIT = 3;
    localparam int IR_GPIO_DATA_BIT = 4;
    localparam int TX_GPIO_DATA_BIT = 5;
    localparam int TX_GPIO_POL_BIT = 6;
    localparam logic [6:0] CONTROL_RESET = 7'h00;
    // Timeout register
    localparam logic [6:0] TIMEOUT_RESET = 7'h00;
    localparam logic [6:0] TIMEOUT_MAX = 7'h64;
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int STEP_US = 100;
    localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
    localparam int CARRIER_KHZ = 500;
    localparam int CARRIER_HALF_CYCLES = (CLK_MHZ * 1000) / (2 * CARRIER_KHZ);
    localparam logic [9:0] ASK_HOLD_CYCLES = 10'(4 * CARRIER_HALF_CYCLES);
    localparam logic [3:0] PULSE_TICKS = 4'h3;
    localparam logic [3:0] BIT_TICKS = 4'hf;
    typedef enum logic [1:0] {
        MODE_PLAIN = 2'b00,
        MODE_PULSE = 2'b01,
        MODE_ASK = 2'b10
    } ir_mode_t;
endpackage : infrared_port_frontend_pkg

// file: infrared_port_frontend_test.sv
// Self-checking testbench for the infrared port front end
`timescale 1ns/100ps
`default_nettype none
module infrared_port_frontend_test
    import infrared_port_frontend_pkg::*;
;
    typedef struct packed {logic err; logic [31:0] data;} rd_note_t;
    logic i_clk = 0, i_rst = 1, i_main_por = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, txd = 1, bit_start = 0, tx_busy = 0, rx_busy = 0, tick = 0;
    logic fire = 0, o_uart_rxd, o_uart_tx_hold, ir_out, tx_pin, tx_oe;
    logic std_rx = 1'b0;
    logic [1:0] tcnt = 2'h0;
    logic [6:0] tmo;
    wire light;
    rd_note_t rd_q[$];
    rd_note_t note;
    int err_count = 0, compares = 0, hi = 0;
    infrared_port_frontend #(.STEP_CYC(10)) u_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_main_por(i_main_por), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_uart_txd(txd),
        .i_uart_bit_start(bit_start), .i_uart_tx_busy(tx_busy), .i_uart_rx_busy(rx_busy),
        .i_baud_tick16(tick), .o_uart_rxd(o_uart_rxd), .o_uart_tx_hold(o_uart_tx_hold),
        .i_infrared_in_pin(light), .i_second_serial_rx_pin(std_rx),
        .o_infrared_out_pin(ir_out), .o_second_serial_tx_pin(tx_pin),
        .o_second_serial_tx_pin_oe(tx_oe));
    ir_remote_model u_remote (.i_clk(i_clk), .i_fire(fire), .o_light(light));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and baud tick
    always #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Reporting
    task automatic print_verdict();
        if (err_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    task automatic compare_rd(input rd_note_t got, input rd_note_t exp);
        compares++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : compare_rd
    task automatic compare_pin(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : compare_pin
    ////////////////////////////////////////////////////////////////////////////////
    // Read monitor
    always @(posedge i_clk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (rd_q.size() == 0) begin
                err_count++;
            end else begin
                note = rd_q.pop_front();
                compare_rd({pslverr, prdata}, note);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Stimulus tasks
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask : wait_cyc
    task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_count++;
            print_verdict();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clk);
    endtask : apb_xfer
    task automatic apb_read(input logic [7:0] a, input logic [31:0] exp, input logic e);
        rd_q.push_back({e, exp});
        apb_xfer(1'b0, a, 32'h0000_0000);
    endtask : apb_read
    task automatic send_bit(input logic b);
        bit_start <= 1'b1;
        txd <= b;
        @(posedge i_clk);
        bit_start <= 1'b0;
    endtask : send_bit
    task automatic busy_pulse(input logic rx);
        if (rx) rx_busy <= 1'b1; else tx_busy <= 1'b1;
        wait_cyc(5);
        rx_busy <= 1'b0;
        tx_busy <= 1'b0;
        wait_cyc(3);
    endtask : busy_pulse
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'h543de996));
        wait_cyc(5);
        i_rst <= 1'b0;
        wait_cyc(1);
        compare_pin(tx_oe, 1'b1);
        compare_pin(tx_pin, 1'b0);
        compare_pin(ir_out, 1'b0);
        apb_read(ADDR_MODE, {24'h0, MODE_RESET}, 1'b0);
        apb_read(ADDR_CONTROL, {25'h0, CONTROL_RESET}, 1'b0);
        apb_read(ADDR_TIMEOUT, {25'h0, TIMEOUT_RESET}, 1'b0);
        apb_xfer(1'b1, 8'h0c, 32'hffff_ffff);
        apb_read(8'h0c, 32'h0000_0000, 1'b1);
        tmo = 7'($urandom_range(100, 0));
        apb_xfer(1'b1, ADDR_TIMEOUT, {25'h0, tmo});
        apb_read(ADDR_TIMEOUT, {25'h0, tmo}, 1'b0);
        apb_xfer(1'b1, ADDR_TIMEOUT, 32'h0000_007f);
        apb_read(ADDR_TIMEOUT, {25'h0, TIMEOUT_MAX}, 1'b0);
        apb_xfer(1'b1, ADDR_CONTROL, 32'h0000_0020);
        wait_cyc(3);
        compare_pin(tx_pin, 1'b1);
        apb_xfer(1'b1, ADDR_CONTROL, 32'h0000_0040);
        wait_cyc(3);
        compare_pin(tx_pin, 1'b1);
        apb_xfer(1'b1, ADDR_CONTROL, 32'h0000_0004);
        wait_cyc(3);
        compare_pin(tx_pin, 1'b0);
        apb_xfer(1'b1, ADDR_CONTROL, 32'h0000_0005);
        wait_cyc(3);
        compare_pin(tx_pin, 1'b1);
        txd <= 1'b0;
        wait_cyc(3);
        compare_pin(tx_pin, 1'b0);
        apb_xfer(1'b1, ADDR_CONTROL, 32'h0000_0000);
        apb_xfer(1'b1, ADDR_MODE, 32'h0000_0009);
        send_bit(1'b0);
        wait_cyc(3);
        compare_pin(ir_out, 1'b0);
        wait_cyc(60);
        apb_xfer(1'b1, ADDR_CONTROL, 32'h0000_0001);
        send_bit(1'b0);
        wait_cyc(3);
        compare_pin(ir_out, 1'b1);
        wait_cyc(30);
        compare_pin(ir_out, 1'b0);
        send_bit(1'b1);
        wait_cyc(3);
        compare_pin(ir_out, 1'b0);
        wait_cyc(60);
        apb_xfer(1'b1, ADDR_MODE, 32'h0000_000a);
        txd <= 1'b0;
        wait_cyc(3);
        hi = 0;
        repeat (2 * CARRIER_HALF_CYCLES) begin
            @(posedge i_clk);
            hi += int'(ir_out);
        end
        compare_rd({1'b0, hi}, {1'b0, 32'(CARRIER_HALF_CYCLES)});
        txd <= 1'b1;
        fire <= 1'b1;
        wait_cyc(1);
        fire <= 1'b0;
        wait_cyc(5);
        compare_pin(o_uart_rxd, 1'b0);
        wait_cyc(20);
        apb_xfer(1'b1, ADDR_CONTROL, 32'h0000_001a);
        wait_cyc(3);
        compare_pin(ir_out, 1'b1);
        apb_xfer(1'b1, ADDR_MODE, 32'h0000_0029);
        wait_cyc(3);
        compare_pin(tx_oe, 1'b0);
        compare_pin(ir_out, 1'b1);
        i_main_por <= 1'b1;
        wait_cyc(3);
        i_main_por <= 1'b0;
        wait_cyc(6);
        compare_pin(tx_oe, 1'b0);
        compare_pin(ir_out, 1'b0);
        apb_read(ADDR_MODE, 32'h0000_0020, 1'b0);
        i_rst <= 1'b1;
        wait_cyc(2);
        i_rst <= 1'b0;
        wait_cyc(1);
        compare_pin(tx_oe, 1'b1);
        std_rx <= 1'b1;
        wait_cyc(5);
        compare_pin(o_uart_rxd, 1'b1);
        std_rx <= 1'b0;
        wait_cyc(5);
        compare_pin(o_uart_rxd, 1'b0);
        std_rx <= 1'b1;
        apb_xfer(1'b1, ADDR_TIMEOUT, 32'h0000_0002);
        apb_xfer(1'b1, ADDR_MODE, 32'h0000_000d);
        apb_xfer(1'b1, ADDR_CONTROL, 32'h0000_0001);
        busy_pulse(1'b0);
        fire <= 1'b1;
        wait_cyc(1);
        fire <= 1'b0;
        wait_cyc(4);
        compare_pin(o_uart_rxd, 1'b1);
        wait_cyc(40);
        fire <= 1'b1;
        wait_cyc(1);
        fire <= 1'b0;
        wait_cyc(4);
        compare_pin(o_uart_rxd, 1'b0);
        wait_cyc(40);
        busy_pulse(1'b1);
        compare_pin(o_uart_tx_hold, 1'b1);
        wait_cyc(40);
        compare_pin(o_uart_tx_hold, 1'b0);
        busy_pulse(1'b1);
        wait_cyc(7);
        busy_pulse(1'b1);
        wait_cyc(5);
        compare_pin(o_uart_tx_hold, 1'b1);
        print_verdict();
    end
endmodule : infrared_port_frontend_test
`default_nettype wire

// file: ir_remote_model.sv
// Remote infrared device model that flashes light pulses at the receiver
`timescale 1ns/100ps
`default_nettype none
module ir_remote_model #(
    parameter int PULSE_LEN = 12
) (
    input wire logic i_clk,
    input wire logic i_fire,
    output logic o_light
);
    int cnt = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Zero bit is a light pulse, one bit is darkness
    always @(posedge i_clk) begin
        if (i_fire) begin
            cnt <= PULSE_LEN;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign o_light = (cnt > 0);
endmodule : ir_remote_model
`default_nettype wire
